// File: icudma_pkg.sv
// Package for the second drive channel Ultra DMA, test access and transfer mode registers.
package icudma_pkg;
   // Register byte offsets.
   localparam logic [7:0] ICUDMA_OFF_TIMING = 8'hEC;
   localparam logic [7:0] ICUDMA_OFF_TEST = 8'hF0;
   localparam logic [7:0] ICUDMA_OFF_MODE = 8'hF4;
   // Reset values.
   localparam logic [31:0] ICUDMA_RST_TIMING = 32'h4009_4009;
   localparam logic [31:0] ICUDMA_RST_TEST = 32'h0000_0000;
   localparam logic [31:0] ICUDMA_RST_MODE = 32'h0000_0022;
   // Writable bit masks; other bits are reserved and read zero.
   localparam logic [31:0] ICUDMA_MASK_TIMING = 32'hFE7F_FE3F;
   localparam logic [31:0] ICUDMA_MASK_MODE = 32'h0000_0033;
   // Delay step of the strobe and input delays in picoseconds.
   localparam int ICUDMA_DELAY_STEP_PS = 2000;
   // Test module selects.
   localparam logic [3:0] ICUDMA_MOD_DATA_IF = 4'h1;
   localparam logic [3:0] ICUDMA_MOD_TIMER = 4'h2;
   localparam logic [3:0] ICUDMA_MOD_PCI_IF = 4'h3;
   localparam logic [3:0] ICUDMA_MOD_UDMA_WR = 4'h4;
   // Test sub-module selects.
   localparam logic [7:0] ICUDMA_SUB_1 = 8'h01;
   localparam logic [7:0] ICUDMA_SUB_2 = 8'h02;
   localparam logic [7:0] ICUDMA_SUB_3 = 8'h03;
   localparam logic [7:0] ICUDMA_SUB_4 = 8'h04;
   // Transfer mode encodings.
   typedef enum logic [1:0] {
      ICUDMA_XFER_PIO = 2'h0,
      ICUDMA_XFER_PIO_IORDY = 2'h1,
      ICUDMA_XFER_MWDMA = 2'h2,
      ICUDMA_XFER_UDMA = 2'h3
   } icudma_xfer_e;
   // Timing settings of one drive.
   typedef struct packed {
      logic [1:0] data_in_delay;
      logic [1:0] dstrobe_delay;
      logic [2:0] hstrobe_delay;
      logic [5:0] cycle_count;
   } icudma_drive_s;
   // Test access control handed to the counters under test.
   typedef struct packed {
      logic [3:0] module_sel;
      logic [3:0] nibble_sel;
      logic [7:0] sub_sel;
   } icudma_test_s;
endpackage : icudma_pkg

// File: icudma_regs.sv
// Register bank for the second drive channel: Ultra DMA timing, counter test access, mode.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Two-bit data input delay per drive, bits 31:30 and 15:14, 2 ns steps.
// - Two-bit DSTROBE output delay per drive, bits 29:28 and 13:12, 2 ns steps.
// - Three-bit HSTROBE output delay per drive, bits 27:25 and 11:9, 2 ns steps.
// - Six-bit cycle count per drive sets Ultra DMA active and recovery time.
// - Reserved read-only bits read zero; timing bit 22 is reserved read-write.
// - Ultra DMA timing register resets to 4009_4009.
// - Test module select bits 31:28 choose module 1 to 4.
// - Test nibble select bits 27:24 choose control nibble, 0001 lowest.
// - Module and sub-module selects together pick one of eight counters.
// - Test data write preloads the chosen counter; read returns its value.
// - Two-bit transfer mode per drive, bits 5:4 and 1:0, selects the method.
// - Any mode other than 00 enables IORDY monitoring for PIO transfers.
// - Transfer mode register resets to 0000_0022.
module icudma_regs #(
   parameter int NUM_CNT = 8
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Per-drive Ultra DMA settings to the timing engines.
   output icudma_pkg::icudma_drive_s drive0_o,
   output icudma_pkg::icudma_drive_s drive1_o,
   // Per-drive transfer mode and IORDY monitor enable.
   output logic [1:0] drive0_mode_o,
   output logic [1:0] drive1_mode_o,
   output logic drive0_iordy_mon_o,
   output logic drive1_iordy_mon_o,
   // Counter test access: index 0 data, 1..4 timers, 5 byte count, 6 watchdog, 7 write timer.
   output icudma_pkg::icudma_test_s test_ctrl_o,
   output logic [NUM_CNT-1:0] cnt_load_o,
   output logic [15:0] cnt_load_val_o,
   input wire logic [NUM_CNT*16-1:0] cnt_value_i
);

   // Register state.
   logic [31:0] timing_reg;
   logic [31:0] test_reg;
   logic [31:0] mode_reg;
   logic [31:0] next_timing_reg;
   logic [31:0] next_test_reg;
   logic [31:0] next_mode_reg;
   logic [31:0] next_dat;
   logic next_ack;
   logic next_err;
   logic [NUM_CNT-1:0] next_load;
   logic [15:0] next_load_val;
   logic [31:0] wmask;
   logic req;
   logic hit;
   logic [2:0] cnt_idx;
   logic cnt_valid;
   logic [3:0] w_mod;
   logic [7:0] w_sub;
   logic [31:0] wtest;
   logic [3:0] rd_dec;
   logic [3:0] wr_dec;

   // Reset images of the drive settings, taken from the register reset values.
   localparam logic [12:0] ICUDMA_RST_TIMING_LO = {icudma_pkg::ICUDMA_RST_TIMING[15:9],
                                                   icudma_pkg::ICUDMA_RST_TIMING[5:0]};
   localparam logic [12:0] ICUDMA_RST_TIMING_HI = {icudma_pkg::ICUDMA_RST_TIMING[31:25],
                                                   icudma_pkg::ICUDMA_RST_TIMING[21:16]};
   localparam logic [1:0] ICUDMA_RST_MODE0 = icudma_pkg::ICUDMA_RST_MODE[1:0];
   localparam logic [1:0] ICUDMA_RST_MODE1 = icudma_pkg::ICUDMA_RST_MODE[5:4];

   // Byte enables expanded to a bit mask.
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   // A new request is one not yet answered; ack drops in the cycle after it rose.
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign hit = (wb_adr_i == icudma_pkg::ICUDMA_OFF_TIMING) ||
                (wb_adr_i == icudma_pkg::ICUDMA_OFF_TEST) ||
                (wb_adr_i == icudma_pkg::ICUDMA_OFF_MODE);

   // Counter decode from a module and sub-module select, used for reads and writes.
   function automatic logic [3:0] decode(input logic [3:0] m, input logic [7:0] s);
      logic [3:0] r;
      r = 4'h8;
      case (m)
         icudma_pkg::ICUDMA_MOD_DATA_IF: if (s == icudma_pkg::ICUDMA_SUB_1) r = 4'h0;
         icudma_pkg::ICUDMA_MOD_TIMER: begin
            if (s >= icudma_pkg::ICUDMA_SUB_1 && s <= icudma_pkg::ICUDMA_SUB_4) begin
               r = {1'b0, s[2:0]};
            end
         end
         icudma_pkg::ICUDMA_MOD_PCI_IF: begin
            if (s == icudma_pkg::ICUDMA_SUB_1) r = 4'h5;
            else if (s == icudma_pkg::ICUDMA_SUB_2) r = 4'h6;
         end
         icudma_pkg::ICUDMA_MOD_UDMA_WR: if (s == icudma_pkg::ICUDMA_SUB_1) r = 4'h7;
         default: r = 4'h8;
      endcase
      return r;
   endfunction : decode

   // Write-side selects merge the new bytes so a single write can select and preload.
   assign wtest = (test_reg & ~wmask) | (wb_dat_i & wmask);
   assign w_mod = wtest[31:28];
   assign w_sub = wtest[23:16];
   assign wr_dec = decode(w_mod, w_sub);
   // Read-side decode looks only at the stored selects, never at the bus.
   assign rd_dec = decode(test_reg[31:28], test_reg[23:16]);
   assign cnt_valid = ~rd_dec[3];
   assign cnt_idx = rd_dec[2:0];

   // Next state of registers, bus answer and counter preload.
   always_comb begin
      logic [3:0] wd;
      wd = wr_dec;
      next_timing_reg = timing_reg;
      next_test_reg = test_reg;
      next_mode_reg = mode_reg;
      next_dat = 32'h0000_0000;
      next_ack = 1'b0;
      next_err = 1'b0;
      next_load = '0;
      next_load_val = 16'h0000;
      if (req) begin
         next_ack = hit;
         next_err = !hit;
         if (wb_we_i) begin
            case (wb_adr_i)
               icudma_pkg::ICUDMA_OFF_TIMING: begin
                  next_timing_reg = (timing_reg & ~(wmask & icudma_pkg::ICUDMA_MASK_TIMING)) |
                     (wb_dat_i & wmask & icudma_pkg::ICUDMA_MASK_TIMING);
               end
               icudma_pkg::ICUDMA_OFF_TEST: begin
                  next_test_reg = (test_reg & ~wmask) | (wb_dat_i & wmask);
                  if (wb_sel_i[1:0] != 2'h0 && !wd[3]) begin
                     next_load[wd[2:0]] = 1'b1;
                     next_load_val = next_test_reg[15:0];
                  end
               end
               icudma_pkg::ICUDMA_OFF_MODE: begin
                  next_mode_reg = (mode_reg & ~(wmask & icudma_pkg::ICUDMA_MASK_MODE)) |
                     (wb_dat_i & wmask & icudma_pkg::ICUDMA_MASK_MODE);
               end
               default: next_err = 1'b1;
            endcase
         end else begin
            case (wb_adr_i)
               icudma_pkg::ICUDMA_OFF_TIMING: next_dat = timing_reg;
               icudma_pkg::ICUDMA_OFF_TEST: begin
                  next_dat = {test_reg[31:16], 16'h0000};
                  if (cnt_valid) next_dat[15:0] = cnt_value_i[cnt_idx*16 +: 16];
               end
               icudma_pkg::ICUDMA_OFF_MODE: next_dat = mode_reg;
               default: next_dat = 32'h0000_0000;
            endcase
         end
      end
   end

   // Registering of all state; every output comes from a flip-flop.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timing_reg <= icudma_pkg::ICUDMA_RST_TIMING;
         test_reg <= icudma_pkg::ICUDMA_RST_TEST;
         mode_reg <= icudma_pkg::ICUDMA_RST_MODE;
         wb_dat_o <= 32'h0000_0000;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         cnt_load_o <= '0;
         cnt_load_val_o <= 16'h0000;
      end else begin
         timing_reg <= next_timing_reg;
         test_reg <= next_test_reg;
         mode_reg <= next_mode_reg;
         wb_dat_o <= next_dat;
         wb_ack_o <= next_ack;
         wb_err_o <= next_err;
         cnt_load_o <= next_load;
         cnt_load_val_o <= next_load_val;
      end
   end

   // Decoded outputs are registered copies so they follow the registers by one clock.
   // This costs a cycle of latency but keeps every output on a flip-flop.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive0_o <= icudma_pkg::icudma_drive_s'({ICUDMA_RST_TIMING_LO});
         drive1_o <= icudma_pkg::icudma_drive_s'({ICUDMA_RST_TIMING_HI});
         drive0_mode_o <= ICUDMA_RST_MODE0;
         drive1_mode_o <= ICUDMA_RST_MODE1;
         drive0_iordy_mon_o <= (ICUDMA_RST_MODE0 != 2'(icudma_pkg::ICUDMA_XFER_PIO));
         drive1_iordy_mon_o <= (ICUDMA_RST_MODE1 != 2'(icudma_pkg::ICUDMA_XFER_PIO));
         test_ctrl_o <= '0;
      end else begin
         drive0_o <= {timing_reg[15:9], timing_reg[5:0]};
         drive1_o <= {timing_reg[31:25], timing_reg[21:16]};
         drive0_mode_o <= mode_reg[1:0];
         drive1_mode_o <= mode_reg[5:4];
         drive0_iordy_mon_o <= (mode_reg[1:0] != 2'(icudma_pkg::ICUDMA_XFER_PIO));
         drive1_iordy_mon_o <= (mode_reg[5:4] != 2'(icudma_pkg::ICUDMA_XFER_PIO));
         test_ctrl_o <= {test_reg[31:24], test_reg[23:16]};
      end
   end

   // The bus answers one cycle after a request and never twice in a row.
   property p_ack_one;
      @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
   endproperty
   sequence s_req_hit;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && hit;
   endsequence
   // An unmapped address gets an error pulse with zero data and no ack.
   sequence s_req_miss;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !hit;
   endsequence
   AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
      s_req_hit |=> wb_ack_o) else $error("Mapped request not answered next cycle.");
   AST_ACK_DROP: assert property (p_ack_one) else $error("Ack held for two cycles.");
   AST_ERR_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
      s_req_miss |=> wb_err_o && !wb_ack_o && (wb_dat_o == 32'h0000_0000))
      else $error("Unmapped request not refused.");

   // The first edge after reset release must see every register at its reset value.
   sequence s_reset_done;
      $fell(rst_i);
   endsequence
   AST_RESET_REGS: assert property (@(posedge clk_i) disable iff (rst_i)
      s_reset_done |-> (timing_reg == icudma_pkg::ICUDMA_RST_TIMING) &&
      (test_reg == icudma_pkg::ICUDMA_RST_TEST) && (mode_reg == icudma_pkg::ICUDMA_RST_MODE))
      else $error("Register not at reset value after reset.");
   AST_RESET_OUTS: assert property (@(posedge clk_i) disable iff (rst_i)
      s_reset_done |-> (drive0_mode_o == ICUDMA_RST_MODE0) &&
      (drive1_mode_o == ICUDMA_RST_MODE1) && drive0_iordy_mon_o && drive1_iordy_mon_o)
      else $error("Mode outputs not at reset value after reset.");

   // Reserved read-only bits never hold a one, whatever software wrote.
   AST_TIMING_RSVD: assert property (@(posedge clk_i) disable iff (rst_i)
      (timing_reg[24:23] == 2'h0) && (timing_reg[8:6] == 3'h0))
      else $error("Timing reserved bits not zero.");
   AST_MODE_RSVD: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_reg[31:6] == 26'h0 && mode_reg[3:2] == 2'h0)
      else $error("Mode reserved bits not zero.");
   // Timing bit 22 is reserved yet writable, so a write of its byte lane must stick.
   sequence s_timing_wr;
      req && wb_we_i && (wb_adr_i == icudma_pkg::ICUDMA_OFF_TIMING) && wb_sel_i[2];
   endsequence
   AST_TIMING_B22: assert property (@(posedge clk_i) disable iff (rst_i)
      s_timing_wr |=> timing_reg[22] == $past(wb_dat_i[22]))
      else $error("Timing bit 22 not writable.");

   // Settings reach the timing engines one clock after the register changes.
   AST_IORDY_MON: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 drive1_iordy_mon_o == ($past(mode_reg[5:4]) != 2'h0))
      else $error("IORDY monitor does not follow mode.");
   AST_IORDY_MON0: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 drive0_iordy_mon_o == ($past(mode_reg[1:0]) != 2'h0))
      else $error("Drive 0 IORDY monitor does not follow mode.");
   AST_MODE_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 ((drive0_mode_o == $past(mode_reg[1:0])) &&
           (drive1_mode_o == $past(mode_reg[5:4]))))
      else $error("Transfer mode outputs do not follow register.");
   AST_DRIVE0: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 ((drive0_o.data_in_delay == $past(timing_reg[15:14])) &&
           (drive0_o.dstrobe_delay == $past(timing_reg[13:12])) &&
           (drive0_o.hstrobe_delay == $past(timing_reg[11:9])) &&
           (drive0_o.cycle_count == $past(timing_reg[5:0]))))
      else $error("Drive 0 settings do not follow register.");
   AST_DRIVE1: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 ((drive1_o.data_in_delay == $past(timing_reg[31:30])) &&
           (drive1_o.dstrobe_delay == $past(timing_reg[29:28])) &&
           (drive1_o.hstrobe_delay == $past(timing_reg[27:25])) &&
           (drive1_o.cycle_count == $past(timing_reg[21:16]))))
      else $error("Drive 1 settings do not follow register.");

   // Test-data writes: a listed selection with a low byte lane enabled loads one counter, an unlisted one nothing.
   sequence s_test_wr_bad;
      req && wb_we_i && (wb_adr_i == icudma_pkg::ICUDMA_OFF_TEST) && wr_dec[3];
   endsequence
   sequence s_test_wr_good;
      req && wb_we_i && (wb_adr_i == icudma_pkg::ICUDMA_OFF_TEST) && !wr_dec[3] &&
         (wb_sel_i[1:0] != 2'h0);
   endsequence
   AST_BAD_NO_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      s_test_wr_bad |=> cnt_load_o == '0)
      else $error("Unlisted select loaded a counter.");
   AST_GOOD_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      s_test_wr_good |=> $onehot(cnt_load_o) && (cnt_load_val_o == $past(wtest[15:0])))
      else $error("Listed select did not preload its counter.");
   AST_LOAD_ONEHOT: assert property (@(posedge clk_i) disable iff (rst_i)
      $onehot0(cnt_load_o)) else $error("More than one counter loaded.");
   // Reads of an unlisted selection return zero in the data field.
   sequence s_test_rd_bad;
      req && !wb_we_i && (wb_adr_i == icudma_pkg::ICUDMA_OFF_TEST) && !cnt_valid;
   endsequence
   AST_BAD_READ_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      s_test_rd_bad |=> wb_dat_o[15:0] == 16'h0000)
      else $error("Unlisted select read not zero.");
   AST_MODE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && wb_we_i && wb_adr_i == icudma_pkg::ICUDMA_OFF_MODE && wb_sel_i[0])
      |=> mode_reg[1:0] == $past(wb_dat_i[1:0])) else $error("Mode write lost.");

endmodule : icudma_regs
`default_nettype wire

// File: icudma_cnt_model.sv
// Behavioural bank of counters under test that takes preloads from the register bank.
`timescale 1ns/10ps
`default_nettype none
module icudma_cnt_model (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Preload strobes and value.
   input wire logic [7:0] load_i,
   input wire logic [15:0] load_val_i,
   // Counter values, index i at bits 16i+15:16i.
   output logic [127:0] value_o
);
   // Counters hold their preload and never run, so a read-back is predictable.
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 8; i++) begin
         if (rst_i) begin
            value_o[16*i +: 16] <= 16'h7000 + 16'(i);
         end else if (load_i[i]) begin
            value_o[16*i +: 16] <= load_val_i;
         end
      end
   end
endmodule : icudma_cnt_model
`default_nettype wire

// File: icudma_regs_tb.sv
// Self-checking testbench of the second drive channel register bank.
`timescale 1ns/10ps
`default_nettype none
module icudma_regs_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic wb_err_o;
   icudma_pkg::icudma_drive_s d0;
   icudma_pkg::icudma_drive_s d1;
   logic [1:0] m0;
   logic [1:0] m1;
   logic mon0;
   logic mon1;
   icudma_pkg::icudma_test_s tctl;
   logic [7:0] ld;
   logic [15:0] ldv;
   logic [127:0] cnt;
   int error_cnt = 0;
   int checks = 0;
   logic [31:0] q;
   logic e;
   // The clock toggles every half period of 50 ns.
   always #50 clk_i = ~clk_i;
   icudma_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .drive0_o(d0),
      .drive1_o(d1), .drive0_mode_o(m0), .drive1_mode_o(m1), .drive0_iordy_mon_o(mon0),
      .drive1_iordy_mon_o(mon1), .test_ctrl_o(tctl), .cnt_load_o(ld), .cnt_load_val_o(ldv),
      .cnt_value_i(cnt));
   icudma_cnt_model cnts (.clk_i(clk_i), .rst_i(rst_i), .load_i(ld), .load_val_i(ldv),
      .value_o(cnt));
   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One classic cycle: the request stands until ack or err is seen high at a rising edge,
   // the answer is taken at that edge, then cyc and stb stay low for a full cycle.
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
         error_cnt++;
         give_verdict();
      end else begin
         q = wb_dat_o;
         e = wb_err_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask : wb
   task automatic t_reset();
      wb(1'b0, 8'hEC, 32'h0);
      chk(q, 32'h4009_4009);
      wb(1'b0, 8'hF0, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, 8'hF4, 32'h0);
      chk(q, 32'h0000_0022);
      chk({28'h0, m1, m0}, 32'hA);
      chk({30'h0, mon1, mon0}, 32'h3);
      chk({19'h0, d0}, {19'h0, 2'b01, 2'b00, 3'b000, 6'h09});
      chk({19'h0, d1}, {19'h0, 2'b01, 2'b00, 3'b000, 6'h09});
      chk({16'h0, tctl}, 32'h0);
   endtask : t_reset
   task automatic t_timing();
      wb(1'b1, 8'hEC, 32'hFFFF_FFFF);
      wb(1'b0, 8'hEC, 32'h0);
      chk(q, 32'hFE7F_FE3F);
      wb(1'b1, 8'hEC, 32'h9C2A_6C15);
      wb(1'b0, 8'hEC, 32'h0);
      chk(q, 32'h9C2A_6C15);
      chk({19'h0, d1}, {19'h0, 2'b10, 2'b01, 3'b110, 6'h2A});
      chk({19'h0, d0}, {19'h0, 2'b01, 2'b10, 3'b110, 6'h15});
   endtask : t_timing
   task automatic t_mode();
      logic [1:0] m;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         wb(1'b1, 8'hF4, {24'hFF_FFFF, 2'b11, m, 2'b11, ~m});
         wb(1'b0, 8'hF4, 32'h0);
         chk(q, {26'h0, m, 2'b00, ~m});
         chk({28'h0, m1, m0}, {28'h0, m, ~m});
         chk({30'h0, mon1, mon0}, {30'h0, m != 2'b00, m != 2'b11});
      end
   endtask : t_mode
   // Every listed combination preloads its own counter and reads it back.
   task automatic t_test();
      logic [3:0] mods [8] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4};
      logic [7:0] subs [8] = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h04, 8'h01, 8'h02, 8'h01};
      logic [31:0] d;
      for (int i = 0; i < 8; i++) begin
         d = {mods[i], (i % 2 == 1) ? 4'h8 : 4'h1, subs[i], 16'hA0 + 16'(i)};
         wb(1'b1, 8'hF0, d);
         wb(1'b0, 8'hF0, 32'h0);
         chk(q, d);
         chk({16'h0, tctl}, {16'h0, d[31:16]});
         chk({16'h0, cnt[16*i +: 16]}, {16'h0, d[15:0]});
      end
   endtask : t_test
   // Unlisted selects must neither preload nor return a count.
   task automatic t_unlisted();
      wb(1'b1, 8'hF0, 32'h5101_BEEF);
      wb(1'b0, 8'hF0, 32'h0);
      chk(q, 32'h5101_0000);
      wb(1'b1, 8'hF0, 32'h2105_BEEF);
      wb(1'b0, 8'hF0, 32'h0);
      chk(q, 32'h2105_0000);
      for (int i = 0; i < 8; i++) begin
         chk({16'h0, cnt[16*i +: 16]}, 32'hA0 + 32'(i));
      end
      wb(1'b0, 8'hF8, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
   endtask : t_unlisted
   // Byte lanes write on their own; a preload needs one of the two low lanes.
   task automatic t_sel();
      wb(1'b1, 8'hEC, 32'h0, 4'h3);
      wb(1'b0, 8'hEC, 32'h0);
      chk(q, 32'h9C2A_0000);
      wb(1'b1, 8'hF0, 32'h1101_1234, 4'hC);
      wb(1'b0, 8'hF0, 32'h0);
      chk(q, 32'h1101_00A0);
      chk({16'h0, cnt[15:0]}, 32'h0000_00A0);
   endtask : t_sel
   // A reset in mid-run brings every register and output back to its reset value.
   task automatic t_rerst();
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
   endtask : t_rerst
   // Main sequence: four reset cycles, then the scenarios.
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_timing();
      t_mode();
      t_test();
      t_unlisted();
      t_sel();
      t_rerst();
      give_verdict();
   end
endmodule : icudma_regs_tb
`default_nettype wire
